// ### rtl/tear_pkg.sv
// Constants for the translation entry access register block
package tear_pkg;
	localparam logic [3:0]  IDX_PTE      = 4'h8;  // Page table pointer
	localparam logic [3:0]  IDX_ACC      = 4'h9;  // Entry access
	localparam logic [3:0]  IDX_MISC     = 4'ha;  // Way, arm, tag
	localparam int          BASE_LSB     = 22;    // Table base field
	localparam int          BASE_W       = 10;    // Table base width
	localparam int          VPN_LSB      = 2;     // Page number field
	localparam int          VPN_W        = 20;    // Page number width
	localparam int          LINE_W       = 4;     // Line index width
	localparam int          NUM_LINES    = 16;    // Lines in the array
	localparam int          TAG_W        = 16;    // Stored page tag
	localparam int          WAY_W        = 2;     // Used way bits
	localparam int          NUM_WAYS     = 4;     // Ways per line
	localparam int          IDX_W        = 6;     // Entry index width
	localparam int          NUM_ENT      = 64;    // Entries in total
	localparam int          ACC_W        = 25;    // Stored access bits
	localparam int          SPARE_W      = 7;     // Spare bits on top
	localparam int          C_BIT        = 24;    // Cacheable
	localparam int          R_BIT        = 23;    // Load allowed
	localparam int          W_BIT        = 22;    // Store allowed
	localparam int          X_BIT        = 21;    // Execute allowed
	localparam int          G_BIT        = 20;    // Global
	localparam int          PFN_W        = 20;    // Frame number width
	localparam int          WAYF_LSB     = 20;    // Way field position
	localparam int          WAYF_W       = 4;     // Way field width
	localparam int          RD_BIT       = 19;    // Read trigger
	localparam int          WE_BIT       = 18;    // Write arm
	localparam int          PID_LSB      = 4;     // Process tag position
	localparam int          PID_W        = 14;    // Process tag width
	localparam logic [31:0] RST_VAL      = 32'h0; // Reset of all fields
endpackage

// ### rtl/tear_regs.sv
// Translation entry access registers with the entry array behind them
`timescale 1ns/1ps
module tear_regs import tear_pkg::*; (
	input  wire logic              core_clk_in,          // 10 MHz clock
	input  wire logic              sys_rst_in,           // Sync reset
	input  wire logic              ctl_wr_in,            // Control write
	input  wire logic              ctl_rd_in,            // Control read
	input  wire logic [3:0]        ctl_sel_in,           // Register index
	input  wire logic [31:0]       ctl_wdata_in,         // Write data
	output logic      [31:0]       ctl_rdata_out,        // Read data
	input  wire logic              exc_taken_in,         // Exception pulse
	input  wire logic              exc_tlb_miss_in,      // Kind: miss
	input  wire logic              exc_tlb_perm_in,      // Kind: violation
	input  wire logic [VPN_W-1:0]  exc_vpn_in,           // Faulting page
	input  wire logic              eh_clear_in,          // Software clear
	output logic                   in_handler_out,       // Handler flag
	input  wire logic [VPN_W-1:0]  lookup_vpn_in,        // Page to look up
	output logic                   lookup_hit_out,       // Entry matched
	output logic                   lookup_cacheable_out, // Data cacheable
	output logic                   lookup_readable_out,  // Loads allowed
	output logic                   lookup_writable_out,  // Stores allowed
	output logic                   lookup_exec_out,      // Execute allowed
	output logic      [PFN_W-1:0]  lookup_pfn_out        // Frame number
);

	// Entry index from line and way
	function automatic logic [IDX_W-1:0] ent_idx(
		input logic [LINE_W-1:0] line,
		input logic [WAY_W-1:0]  way
	);
		ent_idx = {line, way};
	endfunction

	// Architectural registers
	logic [BASE_W-1:0]  base_ff;              // Table base
	logic [VPN_W-1:0]   vpn_ff;               // Page number
	logic [ACC_W-1:0]   acc_ff;               // Access value, no spare
	logic [PID_W-1:0]   pid_ff;               // Process tag
	logic [WAYF_W-1:0]  way_ff;               // Way select field
	logic               we_ff;                // Write arm
	logic               eh_ff;                // Handler flag
	logic [31:0]        rdata_ff;             // Read data
	// Entry array
	logic               val_mem [NUM_ENT];    // Entry valid
	logic [TAG_W-1:0]   tag_mem [NUM_ENT];    // Page tag
	logic [PID_W-1:0]   pid_mem [NUM_ENT];    // Process tag
	logic [ACC_W-1:0]   acc_mem [NUM_ENT];    // Access bits
	// Lookup result registers
	logic               hit_ff;               // Match seen
	logic [ACC_W-1:0]   hit_acc_ff;           // Matched access bits

	// Access decode
	wire wr_pte  = ctl_wr_in && (ctl_sel_in == IDX_PTE);   // Pointer write
	wire wr_acc  = ctl_wr_in && (ctl_sel_in == IDX_ACC);   // Access write
	wire wr_misc = ctl_wr_in && (ctl_sel_in == IDX_MISC);  // Misc write
	wire tlb_wr  = wr_acc && we_ff;
	wire tlb_rd  = wr_misc && ctl_wdata_in[RD_BIT];
	// Page number update only on the first exception
	wire exc_vpn = exc_taken_in && !eh_ff &&
		(exc_tlb_miss_in || exc_tlb_perm_in);
	// Arm set by violation, or by a miss outside a handler
	wire set_we  = exc_taken_in &&
		(exc_tlb_perm_in || (exc_tlb_miss_in && !eh_ff));

	// Entry selection: line of page number with way
	wire [LINE_W-1:0] cur_line = vpn_ff[LINE_W-1:0];
	wire [IDX_W-1:0]  wr_idx   = ent_idx(cur_line,
		way_ff[WAY_W-1:0]);
	wire [IDX_W-1:0]  rd_idx   = ent_idx(cur_line,
		ctl_wdata_in[WAYF_LSB +: WAY_W]);
	wire [TAG_W-1:0]  rd_tag   = tag_mem[rd_idx];         // Fetched tag
	wire [PID_W-1:0]  rd_pid   = pid_mem[rd_idx];         // Fetched tag
	wire [ACC_W-1:0]  rd_acc   = acc_mem[rd_idx];         // Fetched access

	// Next values
	wire [BASE_W-1:0] nxt_base = wr_pte ?
		ctl_wdata_in[BASE_LSB +: BASE_W] : base_ff;
	wire [VPN_W-1:0]  nxt_vpn  = exc_vpn ? exc_vpn_in :
		tlb_rd ? {rd_tag, cur_line} :
		wr_pte ? ctl_wdata_in[VPN_LSB +: VPN_W] : vpn_ff;
	wire [ACC_W-1:0]  nxt_acc  = tlb_rd ? rd_acc :
		wr_acc ? ctl_wdata_in[ACC_W-1:0] : acc_ff;
	wire [PID_W-1:0]  nxt_pid  = tlb_rd ? rd_pid :
		wr_misc ? ctl_wdata_in[PID_LSB +: PID_W] : pid_ff;
	wire [WAY_W-1:0]  way_inc  = way_ff[WAY_W-1:0] +
		WAY_W'(1);
	wire [WAYF_W-1:0] nxt_way  = tlb_wr ?
		{{(WAYF_W-WAY_W){1'b0}}, way_inc} :
		wr_misc ? ctl_wdata_in[WAYF_LSB +: WAYF_W] : way_ff;
	wire              nxt_we   = set_we ? 1'b1 :
		wr_misc ? ctl_wdata_in[WE_BIT] : we_ff;
	// Set wins over the software clear
	wire              nxt_eh   = exc_taken_in ? 1'b1 :
		eh_clear_in ? 1'b0 : eh_ff;

	// Read view of each register; read trigger reads back zero
	wire [31:0] pte_view  = {base_ff, vpn_ff, 2'b00};
	wire [31:0] acc_view  = {{SPARE_W{1'b0}}, acc_ff};
	wire [31:0] misc_view = {8'h00, way_ff, 1'b0, we_ff,
		pid_ff, 4'h0};
	wire [31:0] nxt_rdata =
		(ctl_sel_in == IDX_PTE)  ? pte_view  :
		(ctl_sel_in == IDX_ACC)  ? acc_view  :
		(ctl_sel_in == IDX_MISC) ? misc_view : 32'h0;

	// Lookup: global entries skip the process tag compare
	logic             lk_hit;                 // Any way matched
	logic [ACC_W-1:0] lk_acc;                 // Access of matching way
	always_comb begin
		lk_hit = 1'b0;
		lk_acc = '0;
		for (int w = 0; w < NUM_WAYS; w++) begin
			if (val_mem[ent_idx(lookup_vpn_in[LINE_W-1:0], WAY_W'(w))] &&
				tag_mem[ent_idx(lookup_vpn_in[LINE_W-1:0], WAY_W'(w))] ==
				lookup_vpn_in[VPN_W-1:LINE_W] &&
				(acc_mem[ent_idx(lookup_vpn_in[LINE_W-1:0],
				WAY_W'(w))][G_BIT] ||
				pid_mem[ent_idx(lookup_vpn_in[LINE_W-1:0], WAY_W'(w))]
				== pid_ff)) begin
				lk_hit = 1'b1;
				lk_acc = acc_mem[ent_idx(lookup_vpn_in[LINE_W-1:0],
					WAY_W'(w))];
			end
		end
	end

	// Register state
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			base_ff  <= RST_VAL[BASE_W-1:0];
			vpn_ff   <= RST_VAL[VPN_W-1:0];
			acc_ff   <= RST_VAL[ACC_W-1:0];
			pid_ff   <= RST_VAL[PID_W-1:0];
			way_ff   <= RST_VAL[WAYF_W-1:0];
			we_ff    <= 1'b0;
			eh_ff    <= 1'b0;
			rdata_ff <= RST_VAL;
		end else begin
			base_ff  <= nxt_base;
			vpn_ff   <= nxt_vpn;
			acc_ff   <= nxt_acc;
			pid_ff   <= nxt_pid;
			way_ff   <= nxt_way;
			we_ff    <= nxt_we;
			eh_ff    <= nxt_eh;
			if (ctl_rd_in) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	// Entry array write: access value with page tag and process tag
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < NUM_ENT; i++) begin
				val_mem[i] <= 1'b0;
				tag_mem[i] <= '0;
				pid_mem[i] <= '0;
				acc_mem[i] <= '0;
			end
		end else if (tlb_wr) begin
			val_mem[wr_idx] <= 1'b1;
			tag_mem[wr_idx] <= vpn_ff[VPN_W-1:LINE_W];
			pid_mem[wr_idx] <= pid_ff;
			acc_mem[wr_idx] <= ctl_wdata_in[ACC_W-1:0];
		end
	end

	// Lookup result registers
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			hit_ff     <= 1'b0;
			hit_acc_ff <= '0;
		end else begin
			hit_ff     <= lk_hit;
			hit_acc_ff <= lk_acc;
		end
	end

	// Outputs
	assign ctl_rdata_out        = rdata_ff;
	assign in_handler_out       = eh_ff;
	assign lookup_hit_out       = hit_ff;
	assign lookup_cacheable_out = hit_acc_ff[C_BIT];
	assign lookup_readable_out  = hit_acc_ff[R_BIT];
	assign lookup_writable_out  = hit_acc_ff[W_BIT];
	assign lookup_exec_out      = hit_acc_ff[X_BIT];
	assign lookup_pfn_out       = hit_acc_ff[PFN_W-1:0];

	// Helper state for entry write checks
	logic [IDX_W-1:0] chk_idx_ff;             // Last written index
	logic [ACC_W-1:0] chk_acc_ff;             // Last written access
	always_ff @(posedge core_clk_in) begin
		chk_idx_ff <= wr_idx;
		chk_acc_ff <= ctl_wdata_in[ACC_W-1:0];
	end

	property p_base_hw;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		!wr_pte |=> base_ff == $past(base_ff);
	endproperty
	a_base_hw: assert property (p_base_hw)
		else $error("table base changed without a write");

	property p_vpn_exc;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		exc_vpn |=> vpn_ff == $past(exc_vpn_in);
	endproperty
	a_vpn_exc: assert property (p_vpn_exc)
		else $error("page number not taken from exception");

	property p_vpn_nest;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		exc_taken_in && eh_ff && !ctl_wr_in |=> $stable(vpn_ff);
	endproperty
	a_vpn_nest: assert property (p_vpn_nest)
		else $error("page number changed by nested exception");

	property p_spare_zero;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		ctl_rd_in && ctl_sel_in == IDX_ACC |=>
			ctl_rdata_out == {{SPARE_W{1'b0}}, $past(acc_ff)};
	endproperty
	a_spare_zero: assert property (p_spare_zero)
		else $error("access read value wrong");

	property p_acc_wr;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		wr_acc |=> acc_ff == $past(ctl_wdata_in[ACC_W-1:0]);
	endproperty
	a_acc_wr: assert property (p_acc_wr)
		else $error("access register not updated");

	property p_ent_wr;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		tlb_wr |=> val_mem[chk_idx_ff] && acc_mem[chk_idx_ff] == chk_acc_ff;
	endproperty
	a_ent_wr: assert property (p_ent_wr)
		else $error("entry not written");

	property p_way_inc;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		tlb_wr |=> way_ff[WAY_W-1:0] == $past(way_inc);
	endproperty
	a_way_inc: assert property (p_way_inc)
		else $error("way did not advance");

	property p_we_set;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		exc_taken_in && exc_tlb_perm_in |=> we_ff;
	endproperty
	a_we_set: assert property (p_we_set)
		else $error("write arm not set");

	property p_pid_rd;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		tlb_rd |=> pid_ff == $past(rd_pid) && acc_ff == $past(rd_acc);
	endproperty
	a_pid_rd: assert property (p_pid_rd)
		else $error("entry read did not load tags");

	property p_eh_set;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		exc_taken_in |=> in_handler_out;
	endproperty
	a_eh_set: assert property (p_eh_set)
		else $error("handler flag not set");

	property p_rst_zero;
		@(posedge core_clk_in)
		sys_rst_in |=> base_ff == '0 && vpn_ff == '0 && acc_ff == '0 &&
			way_ff == '0 && !we_ff;
	endproperty
	a_rst_zero: assert property (p_rst_zero)
		else $error("fields not zero after reset");

	// Matched entry drives the permission outputs a cycle later
	property p_perm_bits;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		lk_hit |=> {lookup_cacheable_out, lookup_readable_out,
			lookup_writable_out, lookup_exec_out} ==
			$past(lk_acc[C_BIT:X_BIT]);
	endproperty
	a_perm_bits: assert property (p_perm_bits)
		else $error("permission outputs differ from entry");

	// A miss grants no hit, load, store or frame number
	property p_miss_zero;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		!lk_hit |=> !lookup_hit_out && !lookup_readable_out &&
			!lookup_writable_out && lookup_pfn_out == '0;
	endproperty
	a_miss_zero: assert property (p_miss_zero)
		else $error("miss left access outputs set");

	// Entry write lands on the line of the page number and the way
	property p_wr_tag;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		tlb_wr |=> tag_mem[{$past(cur_line), $past(way_ff[WAY_W-1:0])}]
			== $past(vpn_ff[VPN_W-1:LINE_W]) &&
			pid_mem[chk_idx_ff] == $past(pid_ff);
	endproperty
	a_wr_tag: assert property (p_wr_tag)
		else $error("entry tag or line wrong");

	// Entry read keeps the line and loads the page tag
	property p_rd_vpn;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		tlb_rd && !exc_vpn |=> $stable(vpn_ff[LINE_W-1:0]) &&
			vpn_ff[VPN_W-1:LINE_W] == $past(rd_tag);
	endproperty
	a_rd_vpn: assert property (p_rd_vpn)
		else $error("entry read did not load page tag");

	// Miss or break inside a handler leaves the arm alone
	property p_we_nest;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		exc_taken_in && eh_ff && !exc_tlb_perm_in && !ctl_wr_in |=>
			$stable(we_ff);
	endproperty
	a_we_nest: assert property (p_we_nest)
		else $error("write arm set by nested miss");

	// Software clear without an exception drops the flag
	property p_eh_clr;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		eh_clear_in && !exc_taken_in |=> !in_handler_out;
	endproperty
	a_eh_clr: assert property (p_eh_clr)
		else $error("handler flag not cleared");

endmodule

// ### tb/tear_regs_bench.sv
// Self-checking bench for the translation entry access registers
`timescale 1ns/1ps
module tear_regs_bench import tear_pkg::*;;
	logic              core_clk_in;   // Bench clock
	logic              sys_rst_in;    // Bench reset
	logic              ctl_wr_in;     // Write strobe
	logic              ctl_rd_in;     // Read strobe
	logic [3:0]        ctl_sel_in;    // Register index
	logic [31:0]       ctl_wdata_in;  // Write data
	logic [31:0]       ctl_rdata_out; // Read data
	logic              exc_taken_in;  // Exception pulse
	logic              exc_miss_in;   // Miss kind
	logic              exc_perm_in;   // Violation kind
	logic [VPN_W-1:0]  exc_vpn_in;    // Faulting page
	logic              eh_clear_in;   // Handler flag clear
	logic              in_handler;    // Handler flag
	logic [VPN_W-1:0]  lookup_vpn_in; // Page looked up
	logic              lk_hit;        // Lookup hit
	logic              lk_c;          // Cacheable
	logic              lk_r;          // Readable
	logic              lk_w;          // Writable
	logic              lk_x;          // Executable
	logic [PFN_W-1:0]  lk_pfn;        // Frame number
	int                n_errors;      // Mismatches seen
	int                checks;        // Comparisons made

	// Device under test
	tear_regs i_tear_regs (
		.core_clk_in         (core_clk_in),
		.sys_rst_in          (sys_rst_in),
		.ctl_wr_in           (ctl_wr_in),
		.ctl_rd_in           (ctl_rd_in),
		.ctl_sel_in          (ctl_sel_in),
		.ctl_wdata_in        (ctl_wdata_in),
		.ctl_rdata_out       (ctl_rdata_out),
		.exc_taken_in        (exc_taken_in),
		.exc_tlb_miss_in     (exc_miss_in),
		.exc_tlb_perm_in     (exc_perm_in),
		.exc_vpn_in          (exc_vpn_in),
		.eh_clear_in         (eh_clear_in),
		.in_handler_out      (in_handler),
		.lookup_vpn_in       (lookup_vpn_in),
		.lookup_hit_out      (lk_hit),
		.lookup_cacheable_out(lk_c),
		.lookup_readable_out (lk_r),
		.lookup_writable_out (lk_w),
		.lookup_exec_out     (lk_x),
		.lookup_pfn_out      (lk_pfn)
	);

	// Clock at 100 ns period
	initial begin
		core_clk_in = 1'b0;
		forever #50 core_clk_in = ~core_clk_in;
	end

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One-cycle control write
	task automatic wr(input logic [3:0] sel, input logic [31:0] d);
		@(posedge core_clk_in);
		ctl_wr_in    <= 1'b1;
		ctl_sel_in   <= sel;
		ctl_wdata_in <= d;
		@(posedge core_clk_in);
		ctl_wr_in    <= 1'b0;
	endtask

	// Control read, data checked the cycle after the strobe
	task automatic rd(input logic [3:0] sel, input logic [31:0] e);
		@(posedge core_clk_in);
		ctl_rd_in  <= 1'b1;
		ctl_sel_in <= sel;
		@(posedge core_clk_in);
		ctl_rd_in  <= 1'b0;
		#1 chk(ctl_rdata_out, e);
	endtask

	// Exception pulse of the given kind
	task automatic exc(input logic m, input logic p, input logic [19:0] v);
		@(posedge core_clk_in);
		exc_taken_in <= 1'b1;
		exc_miss_in  <= m;
		exc_perm_in  <= p;
		exc_vpn_in   <= v;
		@(posedge core_clk_in);
		exc_taken_in <= 1'b0;
		#1 chk({31'h0, in_handler}, 32'h1);
	endtask

	// Lookup: expect {hit, c, r, w, x, pfn}
	task automatic lk(input logic [19:0] v, input logic [24:0] e);
		@(posedge core_clk_in);
		lookup_vpn_in <= v;
		repeat (2) @(posedge core_clk_in);
		#1 chk({7'h0, lk_hit, lk_c, lk_r, lk_w, lk_x, lk_pfn}, {7'h0, e});
	endtask

	// Verdict and end of run
	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		repeat (3000) @(posedge core_clk_in);
		n_errors++;
		end_sim();
	end

	// Main test sequence
	initial begin
		n_errors = 0;
		checks = 0;
		sys_rst_in = 1'b1;
		{ctl_wr_in, ctl_rd_in, exc_taken_in, eh_clear_in} = 4'h0;
		{exc_miss_in, exc_perm_in} = 2'h0;
		ctl_sel_in = 4'h0;
		ctl_wdata_in = 32'h0;
		exc_vpn_in = 20'h0;
		lookup_vpn_in = 20'h0;
		repeat (5) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		rd(IDX_PTE, 32'h0);
		rd(IDX_ACC, 32'h0);
		rd(IDX_MISC, 32'h0);
		rd(4'h3, 32'h0);
		// Arm writes, process tag 5, way 0, page on line 3
		wr(IDX_MISC, 32'h0004_0050);
		wr(IDX_PTE, 32'ha944_8d0c);
		rd(IDX_PTE, 32'ha944_8d0c);
		wr(IDX_ACC, 32'hfffa_bcde);
		rd(IDX_ACC, 32'h01fa_bcde);
		rd(IDX_MISC, 32'h0014_0050);
		// Second entry on line 4, written back to back
		wr(IDX_PTE, 32'ha944_8d10);
		wr(IDX_ACC, 32'h0140_0011);
		rd(IDX_MISC, 32'h0024_0050);
		lk(20'h12343, 25'h1f_abcde);
		lk(20'h12344, 25'h1a_00011);
		// Other process tag, arm off: only the global entry hits
		wr(IDX_MISC, 32'h0020_0060);
		lk(20'h12344, 25'h0);
		lk(20'h12343, 25'h1f_abcde);
		// Entry read from line 4 way 1 with a different page tag
		wr(IDX_PTE, 32'ha955_5550);
		wr(IDX_ACC, 32'h0000_0077);
		rd(IDX_ACC, 32'h0000_0077);
		rd(IDX_MISC, 32'h0020_0060);
		wr(IDX_MISC, 32'h001c_3ff0);
		rd(IDX_ACC, 32'h0140_0011);
		rd(IDX_MISC, 32'h0014_0050);
		rd(IDX_PTE, 32'ha944_8d10);
		// Miss outside a handler loads the page number and arms
		wr(IDX_MISC, 32'h0);
		exc(1'b1, 1'b0, 20'h0beef);
		rd(IDX_PTE, 32'ha942_fbbc);
		rd(IDX_MISC, 32'h0004_0000);
		// Nested miss neither arms nor moves the page number
		wr(IDX_MISC, 32'h0);
		exc(1'b1, 1'b0, 20'h22222);
		rd(IDX_MISC, 32'h0);
		exc(1'b0, 1'b1, 20'h11111);
		rd(IDX_MISC, 32'h0004_0000);
		rd(IDX_PTE, 32'ha942_fbbc);
		@(posedge core_clk_in);
		eh_clear_in <= 1'b1;
		@(posedge core_clk_in);
		eh_clear_in <= 1'b0;
		#1 chk({31'h0, in_handler}, 32'h0);
		end_sim();
	end
endmodule
